// [torque_limit_selector.sv]
// torque limit selector top with wishbone registers
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module torque_limit_selector (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	input  wire logic               limitSelectInput,
	input  wire logic signed [15:0] torqueDemand,
	output logic signed [15:0]      torqueCommand,
	output logic                    limitReachedOutput,
	output logic                    irq
);
	logic [3:0]            limitMethodSelect;
	logic [11:0]           firstLimitValue;
	logic [11:0]           secondLimitValue;
	logic [11:0]           thirdLimitValue;
	logic [11:0]           fourthLimitValue;
	logic [11:0]           regFwdLimit;
	logic [11:0]           regRevLimit;
	logic                  inputNormClosed;
	logic [7:0]            outCode;
	logic [2:0]            irqStatus;
	logic [2:0]            irqMask;
	logic                  selValid;
	logic                  selValidQ;
	logic                  clamped;
	logic                  clampedQ;
	logic                  wrEn;
	logic [3:0]            regIdx;
	logic [11:0]           wrLimit;
	tls_pkg::tls_limits_s  next_limits;
	logic [2:0]            events;

	assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign regIdx = wb_adr_i[5:2];
	// out of range writes saturate so a limit never exceeds full scale
	assign wrLimit = (wb_dat_i[11:0] > tls_pkg::LIMIT_MAX) ?
		tls_pkg::LIMIT_MAX : wb_dat_i[11:0];
	// normally closed wiring reads valid when the pin is low
	assign selValid = limitSelectInput ^ inputNormClosed;

	always_comb
	begin
		next_limits.fwd = firstLimitValue;
		next_limits.rev = firstLimitValue;
		case (limitMethodSelect)
			tls_pkg::METHOD_REG:
			begin
				next_limits.fwd = regFwdLimit;
				next_limits.rev = regRevLimit;
			end
			tls_pkg::METHOD_FIRST:
			begin
				next_limits.fwd = firstLimitValue;
				next_limits.rev = firstLimitValue;
			end
			tls_pkg::METHOD_SPLIT:
			begin
				next_limits.fwd = firstLimitValue;
				next_limits.rev = secondLimitValue;
			end
			tls_pkg::METHOD_INPUT_SAME:
			begin
				next_limits.fwd = selValid ?
					firstLimitValue : secondLimitValue;
				next_limits.rev = selValid ?
					firstLimitValue : secondLimitValue;
			end
			tls_pkg::METHOD_INPUT_SPLIT:
			begin
				next_limits.fwd = selValid ?
					firstLimitValue : thirdLimitValue;
				next_limits.rev = selValid ?
					secondLimitValue : fourthLimitValue;
			end
			default:
			begin
				next_limits.fwd = firstLimitValue;
				next_limits.rev = firstLimitValue;
			end
		endcase
	end

	// one clamp regardless of control mode; torque path always passes it
	tls_clamp u_clamp (
		.clk       (clk),
		.resetn    (resetn),
		.demand    (torqueDemand),
		.limits    (next_limits),
		.torqueOut (torqueCommand),
		.clamped   (clamped)
	);

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			limitMethodSelect <= tls_pkg::METHOD_RESET;
			firstLimitValue <= tls_pkg::LIMIT_RESET;
			secondLimitValue <= tls_pkg::LIMIT_RESET;
			thirdLimitValue <= tls_pkg::LIMIT_RESET;
			fourthLimitValue <= tls_pkg::LIMIT_RESET;
			regFwdLimit <= 12'h000;
			regRevLimit <= 12'h000;
			inputNormClosed <= 1'b0;
			outCode <= tls_pkg::OUT_CODE_RESET;
			irqMask <= 3'h0;
		end
		else if (wrEn && wb_sel_i[0])
		begin
			case (regIdx)
				tls_pkg::ADR_METHOD:
					limitMethodSelect <= wb_dat_i[3:0];
				tls_pkg::ADR_LIMIT1:
					firstLimitValue <= wrLimit;
				tls_pkg::ADR_LIMIT2:
					secondLimitValue <= wrLimit;
				tls_pkg::ADR_LIMIT3:
					thirdLimitValue <= wrLimit;
				tls_pkg::ADR_LIMIT4:
					fourthLimitValue <= wrLimit;
				tls_pkg::ADR_CONFIG:
					inputNormClosed <= wb_dat_i[tls_pkg::CFG_NC_BIT];
				tls_pkg::ADR_IRQMASK:
					irqMask <= wb_dat_i[2:0];
				tls_pkg::ADR_REGFWD:
					regFwdLimit <= wrLimit;
				tls_pkg::ADR_REGREV:
					regRevLimit <= wrLimit;
				default:
					limitMethodSelect <= limitMethodSelect;
			endcase
		end
		if (resetn && wrEn && wb_sel_i[1] && regIdx == tls_pkg::ADR_CONFIG)
			outCode <= wb_dat_i[15:8];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			clampedQ <= 1'b0;
			selValidQ <= 1'b0;
			limitReachedOutput <= 1'b0;
		end
		else
		begin
			clampedQ <= clamped;
			selValidQ <= selValid;
			// high means the output contact is closed
			if (outCode == tls_pkg::OUT_CODE_OPEN)
				limitReachedOutput <= !clamped;
			else if (outCode == tls_pkg::OUT_CODE_CLOSE)
				limitReachedOutput <= clamped;
			else
				limitReachedOutput <= 1'b0;
		end
	end

	assign events = {selValid != selValidQ, clampedQ && !clamped,
		clamped && !clampedQ};

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!resetn)
			irqStatus <= 3'h0;
		else if (wrEn && wb_sel_i[0] && regIdx == tls_pkg::ADR_IRQSTAT)
			irqStatus <= (irqStatus & ~wb_dat_i[2:0]) | events;
		else
			irqStatus <= irqStatus | events;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= |(irqStatus & irqMask);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= 32'h0000_0000;
			if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
			begin
				case (regIdx)
					tls_pkg::ADR_METHOD:
						wb_dat_o <= {28'h0, limitMethodSelect};
					tls_pkg::ADR_LIMIT1:
						wb_dat_o <= {20'h0, firstLimitValue};
					tls_pkg::ADR_LIMIT2:
						wb_dat_o <= {20'h0, secondLimitValue};
					tls_pkg::ADR_LIMIT3:
						wb_dat_o <= {20'h0, thirdLimitValue};
					tls_pkg::ADR_LIMIT4:
						wb_dat_o <= {20'h0, fourthLimitValue};
					tls_pkg::ADR_CONFIG:
						wb_dat_o <= {16'h0, outCode, 7'h0, inputNormClosed};
					tls_pkg::ADR_STATUS:
						wb_dat_o <= {29'h0, selValid, limitReachedOutput,
							clamped};
					tls_pkg::ADR_IRQSTAT:
						wb_dat_o <= {29'h0, irqStatus};
					tls_pkg::ADR_IRQMASK:
						wb_dat_o <= {29'h0, irqMask};
					tls_pkg::ADR_REGFWD:
						wb_dat_o <= {20'h0, regFwdLimit};
					tls_pkg::ADR_REGREV:
						wb_dat_o <= {20'h0, regRevLimit};
					default:
						wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	sel_same_a: assert property (
		@(posedge clk) disable iff (!resetn)
		limitMethodSelect == tls_pkg::METHOD_INPUT_SAME && selValid
		|-> next_limits.fwd == firstLimitValue
		&& next_limits.rev == firstLimitValue)
		else $error("method 3 valid wrong");
	sel_same_inv_a: assert property (
		@(posedge clk) disable iff (!resetn)
		limitMethodSelect == tls_pkg::METHOD_INPUT_SAME && !selValid
		|-> next_limits.fwd == secondLimitValue
		&& next_limits.rev == secondLimitValue)
		else $error("method 3 invalid wrong");
	sel_polarity_a: assert property (
		@(posedge clk) disable iff (!resetn)
		inputNormClosed |-> selValid == !limitSelectInput)
		else $error("polarity wrong");
	split_valid_a: assert property (
		@(posedge clk) disable iff (!resetn)
		limitMethodSelect == tls_pkg::METHOD_INPUT_SPLIT && selValid
		|-> next_limits.fwd == firstLimitValue
		&& next_limits.rev == secondLimitValue)
		else $error("method 5 valid wrong");
	split_invalid_a: assert property (
		@(posedge clk) disable iff (!resetn)
		limitMethodSelect == tls_pkg::METHOD_INPUT_SPLIT && !selValid
		|-> next_limits.fwd == thirdLimitValue
		&& next_limits.rev == fourthLimitValue)
		else $error("method 5 invalid wrong");
	limit_range_a: assert property (
		@(posedge clk) disable iff (!resetn)
		firstLimitValue <= tls_pkg::LIMIT_MAX
		&& secondLimitValue <= tls_pkg::LIMIT_MAX
		&& thirdLimitValue <= tls_pkg::LIMIT_MAX
		&& fourthLimitValue <= tls_pkg::LIMIT_MAX)
		else $error("limit out of range");
	limit_store_a: assert property (
		@(posedge clk) disable iff (!resetn)
		wrEn && wb_sel_i[0] && regIdx == tls_pkg::ADR_LIMIT1
		|=> firstLimitValue == $past(wrLimit))
		else $error("limit write lost");
	out_close_a: assert property (
		@(posedge clk) disable iff (!resetn)
		outCode == tls_pkg::OUT_CODE_CLOSE && $stable(outCode)
		|=> limitReachedOutput == $past(clamped))
		else $error("code 15 output wrong");
	out_open_a: assert property (
		@(posedge clk) disable iff (!resetn)
		outCode == tls_pkg::OUT_CODE_OPEN && $stable(outCode)
		|=> limitReachedOutput == !$past(clamped))
		else $error("code 16 output wrong");
	out_other_a: assert property (
		@(posedge clk) disable iff (!resetn)
		outCode != tls_pkg::OUT_CODE_CLOSE
		&& outCode != tls_pkg::OUT_CODE_OPEN |=> !limitReachedOutput)
		else $error("unassigned output driven");
	method_first_a: assert property (
		@(posedge clk) disable iff (!resetn)
		limitMethodSelect == tls_pkg::METHOD_FIRST
		|-> next_limits.fwd == firstLimitValue
		&& next_limits.rev == firstLimitValue)
		else $error("method 1 wrong");
	reach_set_a: assert property (
		@(posedge clk) disable iff (!resetn)
		clamped && !clampedQ |=> irqStatus[tls_pkg::IRQ_REACH])
		else $error("reach event lost");
	release_set_a: assert property (
		@(posedge clk) disable iff (!resetn)
		clampedQ && !clamped |=> irqStatus[tls_pkg::IRQ_RELEASE])
		else $error("release event lost");
	selchg_set_a: assert property (
		@(posedge clk) disable iff (!resetn)
		selValid != selValidQ |=> irqStatus[tls_pkg::IRQ_SELCHG])
		else $error("select change event lost");
	status_sticky_a: assert property (
		@(posedge clk) disable iff (!resetn)
		irqStatus[tls_pkg::IRQ_REACH] && !(wrEn && wb_sel_i[0]
		&& regIdx == tls_pkg::ADR_IRQSTAT && wb_dat_i[tls_pkg::IRQ_REACH])
		|=> irqStatus[tls_pkg::IRQ_REACH])
		else $error("status bit lost");
	irq_level_a: assert property (
		@(posedge clk) disable iff (!resetn)
		|(irqStatus & irqMask) |=> irq)
		else $error("irq missing");
	irq_quiet_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!(|(irqStatus & irqMask)) |=> !irq)
		else $error("irq without cause");
	ack_once_a: assert property (
		@(posedge clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	ack_answer_a: assert property (
		@(posedge clk) disable iff (!resetn)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	read_unmapped_a: assert property (
		@(posedge clk) disable iff (!resetn)
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
		&& regIdx > tls_pkg::ADR_REGREV |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	same_cov: cover property (@(posedge clk)
		limitMethodSelect == tls_pkg::METHOD_INPUT_SAME && clamped);
	split_cov: cover property (@(posedge clk)
		limitMethodSelect == tls_pkg::METHOD_INPUT_SPLIT && !selValid);
	irq_cov: cover property (@(posedge clk) irq);
	open_cov: cover property (@(posedge clk)
		outCode == tls_pkg::OUT_CODE_OPEN && clamped);
	clear_cov: cover property (@(posedge clk)
		wrEn && regIdx == tls_pkg::ADR_IRQSTAT);
endmodule : torque_limit_selector
`default_nettype wire

// [tls_pkg.sv]
// package of constants and types for the torque limit selector
package tls_pkg;
	localparam int LIMIT_W = 12;
	localparam int TORQUE_W = 16;
	localparam logic [11:0] LIMIT_MAX = 12'hBB8;
	localparam logic [11:0] LIMIT_RESET = 12'hBB8;
	localparam logic [3:0] METHOD_RESET = 4'h1;
	localparam logic [3:0] METHOD_REG = 4'h0;
	localparam logic [3:0] METHOD_FIRST = 4'h1;
	localparam logic [3:0] METHOD_SPLIT = 4'h2;
	localparam logic [3:0] METHOD_INPUT_SAME = 4'h3;
	localparam logic [3:0] METHOD_INPUT_SPLIT = 4'h5;
	localparam logic [7:0] OUT_CODE_CLOSE = 8'h0F;
	localparam logic [7:0] OUT_CODE_OPEN = 8'h10;
	localparam logic [7:0] OUT_CODE_RESET = 8'h0F;
	localparam logic [3:0] ADR_METHOD = 4'h0;
	localparam logic [3:0] ADR_LIMIT1 = 4'h1;
	localparam logic [3:0] ADR_LIMIT2 = 4'h2;
	localparam logic [3:0] ADR_LIMIT3 = 4'h3;
	localparam logic [3:0] ADR_LIMIT4 = 4'h4;
	localparam logic [3:0] ADR_CONFIG = 4'h5;
	localparam logic [3:0] ADR_STATUS = 4'h6;
	localparam logic [3:0] ADR_IRQSTAT = 4'h7;
	localparam logic [3:0] ADR_IRQMASK = 4'h8;
	localparam logic [3:0] ADR_REGFWD = 4'h9;
	localparam logic [3:0] ADR_REGREV = 4'hA;
	localparam int CFG_NC_BIT = 0;
	localparam int CFG_CODE_LSB = 8;
	localparam int IRQ_W = 3;
	localparam int IRQ_REACH = 0;
	localparam int IRQ_RELEASE = 1;
	localparam int IRQ_SELCHG = 2;
	typedef struct packed {
		logic [11:0] fwd;
		logic [11:0] rev;
	} tls_limits_s;
endpackage : tls_pkg

// [tls_clamp.sv]
// clamp of a signed torque demand to a forward/reverse limit pair
`timescale 1ns/1ns
`default_nettype none
module tls_clamp (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic signed [15:0]   demand,
	input  wire tls_pkg::tls_limits_s limits,
	output logic signed [15:0]        torqueOut,
	output logic                      clamped
);
	logic signed [15:0] fwdS;
	logic signed [15:0] revS;
	assign fwdS = $signed({4'h0, limits.fwd});
	assign revS = -$signed({4'h0, limits.rev});

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			torqueOut <= 16'sh0000;
			clamped <= 1'b0;
		end
		else if (demand > fwdS)
		begin
			torqueOut <= fwdS;
			clamped <= 1'b1;
		end
		else if (demand < revS)
		begin
			torqueOut <= revS;
			clamped <= 1'b1;
		end
		else
		begin
			torqueOut <= demand;
			clamped <= 1'b0;
		end
	end

	clamp_bound_a: assert property (
		@(posedge clk) disable iff (!resetn)
		torqueOut <= fwdS || $changed(limits))
		else $error("over fwd");
endmodule : tls_clamp
`default_nettype wire

// [tls_drive_model.sv]
// drive side model: torque demand source and limit select pin
`timescale 1ns/1ns
`default_nettype none
module tls_drive_model (
	input  wire logic               clk,
	input  wire logic signed [15:0] demandReq,
	input  wire logic               pinReq,
	output logic signed [15:0]      torqueDemand,
	output logic                    limitSelectInput
);
	// the loop updates right after an edge, never between edges
	always @(posedge clk)
	begin
		torqueDemand <= demandReq;
		limitSelectInput <= pinReq;
	end
endmodule : tls_drive_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the torque limit selector
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic               clk = 1'b0;
	logic               resetn = 1'b0;
	logic               cyc = 1'b0;
	logic               stb = 1'b0;
	logic               we = 1'b0;
	logic [7:0]         adr = 8'h00;
	logic [3:0]         sel = 4'h0;
	logic [31:0]        dat = 32'h0000_0000;
	logic [31:0]        datO;
	logic               ack;
	logic signed [15:0] demandReq = 16'h0000;
	logic               pinReq = 1'b0;
	logic signed [15:0] demand;
	logic               selPin;
	logic signed [15:0] torqueCommand;
	logic               limitReachedOutput;
	logic               irq;
	int                 errTotal = 0;
	int                 checksDone = 0;

	always #2 clk = ~clk;

	tls_drive_model tls_drive_model_inst (
		.clk              (clk),
		.demandReq        (demandReq),
		.pinReq           (pinReq),
		.torqueDemand     (demand),
		.limitSelectInput (selPin)
	);

	torque_limit_selector torque_limit_selector_inst (
		.clk                (clk),
		.resetn             (resetn),
		.wb_cyc_i           (cyc),
		.wb_stb_i           (stb),
		.wb_we_i            (we),
		.wb_adr_i           (adr),
		.wb_sel_i           (sel),
		.wb_dat_i           (dat),
		.wb_dat_o           (datO),
		.wb_ack_o           (ack),
		.limitSelectInput   (selPin),
		.torqueDemand       (demand),
		.torqueCommand      (torqueCommand),
		.limitReachedOutput (limitReachedOutput),
		.irq                (irq)
	);

	task automatic summarize();
		if (errTotal == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			errTotal++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// classic cycle: the request stands until ack is seen high at an edge;
	// only the watchdog ends a wait that never gets its answer
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(q, exp);
	endtask : rd

	task automatic tq(input logic [15:0] d, input logic p,
		input logic [15:0] c, input logic lro);
		demandReq <= d;
		pinReq <= p;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check({torqueCommand, 15'h0000, limitReachedOutput}, {c, 15'h0000, lro});
		@(posedge clk);
	endtask : tq

	task automatic irqIs(input logic e);
		repeat (2) @(negedge clk);
		check({31'h0, irq}, {31'h0, e});
		@(posedge clk);
	endtask : irqIs

	initial
	begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 1; i < 5; i++)
			rd(8'(4 * i), 32'h0000_0BB8);
		rd(8'h00, 32'h0000_0001);
		wr(8'h04, 32'h0000_0FA0);
		rd(8'h04, 32'h0000_0BB8);
		wr(8'h04, 32'h0000_0064);
		wr(8'h08, 32'h0000_00C8);
		wr(8'h0C, 32'h0000_012C);
		wr(8'h10, 32'h0000_0190);
		wr(8'h00, 32'h0000_0003);
		wr(8'h14, {16'h0000, tls_pkg::OUT_CODE_CLOSE, 8'h00});
		tq(16'h01F4, 1'b1, 16'h0064, 1'b1);
		tq(16'hFE0C, 1'b1, 16'hFF9C, 1'b1);
		tq(16'h01F4, 1'b0, 16'h00C8, 1'b1);
		tq(16'h0096, 1'b0, 16'h0096, 1'b0);
		wr(8'h14, 32'h0000_0F01);
		tq(16'h01F4, 1'b0, 16'h0064, 1'b1);
		tq(16'hFE0C, 1'b1, 16'hFF38, 1'b1);
		wr(8'h14, 32'h0000_0F00);
		wr(8'h00, 32'h0000_0005);
		tq(16'h01F4, 1'b1, 16'h0064, 1'b1);
		tq(16'hFE0C, 1'b1, 16'hFF38, 1'b1);
		tq(16'h01F4, 1'b0, 16'h012C, 1'b1);
		tq(16'hFE0C, 1'b0, 16'hFE70, 1'b1);
		wr(8'h14, {16'h0000, tls_pkg::OUT_CODE_OPEN, 8'h00});
		tq(16'h01F4, 1'b0, 16'h012C, 1'b0);
		tq(16'h0032, 1'b0, 16'h0032, 1'b1);
		wr(8'h14, 32'h0000_0F00);
		wr(8'h1C, 32'h0000_0007);
		wr(8'h20, 32'h0000_0001);
		irqIs(1'b0);
		tq(16'h01F4, 1'b0, 16'h012C, 1'b1);
		irqIs(1'b1);
		wr(8'h20, 32'h0000_0000);
		irqIs(1'b0);
		wr(8'h20, 32'h0000_0001);
		irqIs(1'b1);
		rd(8'h1C, 32'h0000_0001);
		rd(8'h18, 32'h0000_0003);
		wr(8'h1C, 32'h0000_0001);
		irqIs(1'b0);
		wr(8'h24, 32'h0000_0050);
		wr(8'h28, 32'h0000_003C);
		wr(8'h00, 32'h0000_0000);
		tq(16'h01F4, 1'b0, 16'h0050, 1'b1);
		tq(16'hFE0C, 1'b0, 16'hFFC4, 1'b1);
		wr(8'h00, 32'h0000_0002);
		wr(8'h14, 32'h0000_0100);
		tq(16'hFE0C, 1'b0, 16'hFF38, 1'b0);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0000_0000);
		// second reset in mid-run, with a demand still applied
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h00, 32'h0000_0001);
		rd(8'h10, 32'h0000_0BB8);
		rd(8'h14, 32'h0000_0F00);
		irqIs(1'b0);
		tq(16'h0032, 1'b1, 16'h0032, 1'b0);
		rd(8'h1C, 32'h0000_0004);
		summarize();
	end

	// the sequence needs under three hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		errTotal++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
